// ### logic/card_interface_config_regs.sv
`default_nettype none
module card_interface_config_regs (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Register byte port from the two-wire front end
	input wire logic i_reg_wr_en,
	input wire logic [card_cfg_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [card_cfg_pkg::DATA_W-1:0] i_reg_wdata,
	output logic [card_cfg_pkg::DATA_W-1:0] o_reg_rdata,
	// Supply control
	input wire logic i_dcdc_on,
	output logic o_boost_en,
	output logic o_supply_glitch_monitor_en,
	// Presence and interrupt
	input wire logic i_card_present,
	input wire logic i_insert_irq,
	input wire logic i_card_supply_irq,
	input wire logic i_other_irq,
	output logic o_pullup_en,
	output logic o_presence_irq_pin_o,
	output logic o_presence_irq_pin_oe,
	// Card reset
	input wire logic i_host_reset_in_pin,
	input wire logic i_hw_activation,
	output logic o_hw_activate_allowed,
	output logic o_card_reset_pin,
	// Card clock
	input wire logic i_card_clk_tick,
	output logic o_card_clock_pin,
	// Contact pins
	input wire logic i_host_io_pin,
	input wire logic i_host_c4_pin,
	input wire logic i_host_c8_pin,
	input wire logic i_card_io_pin,
	output logic o_card_io_pin_o,
	output logic o_card_io_pin_oe,
	output logic o_card_c4_pin,
	output logic o_card_c8_pin,
	output logic o_host_io_pin_o,
	output logic o_host_io_pin_oe
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	localparam int NP = card_cfg_pkg::PIN_COUNT;
	localparam int NS = card_cfg_pkg::SYNC_STAGES;

	logic [NP-1:0] pin_raw;
	logic [NP-1:0] pin_sync;

	assign pin_raw = {i_host_reset_in_pin, i_card_io_pin, i_host_c8_pin,
		i_host_c4_pin, i_host_io_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_sync
			logic [NS-1:0] stage_reg;
			always_ff @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					stage_reg <= {NS{1'b1}};
				end else begin
					stage_reg <= {stage_reg[NS-2:0], pin_raw[gi]};
				end
			end
			assign pin_sync[gi] = stage_reg[NS-1];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] cfg_reg;
	logic [7:0] ctl_reg;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_reg <= card_cfg_pkg::CFG_RESET;
		end else if (i_reg_wr_en &&
				i_reg_addr == card_cfg_pkg::ADDR_POWER_IRQ_CFG) begin
			// Reserved top bits are never stored
			cfg_reg <= i_reg_wdata & card_cfg_pkg::CFG_WRITE_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctl_reg <= card_cfg_pkg::CTL_RESET;
		end else if (i_reg_wr_en &&
				i_reg_addr == card_cfg_pkg::ADDR_CONTACT_CTL) begin
			ctl_reg <= i_reg_wdata & card_cfg_pkg::CTL_WRITE_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_addr == card_cfg_pkg::ADDR_POWER_IRQ_CFG) begin
			o_reg_rdata <= cfg_reg;
		end else if (i_reg_addr == card_cfg_pkg::ADDR_CONTACT_CTL) begin
			o_reg_rdata <= ctl_reg;
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	logic boost_bypass;
	logic irq_source_gate;
	logic card_reset_source_sel;
	logic card_clock_halt;
	logic card_clock_level;

	assign boost_bypass = cfg_reg[card_cfg_pkg::CFG_BOOST_BYPASS_BIT];
	assign irq_source_gate = cfg_reg[card_cfg_pkg::CFG_IRQ_GATE_BIT];
	assign card_reset_source_sel = cfg_reg[card_cfg_pkg::CFG_RST_SRC_BIT];
	assign card_clock_halt = ctl_reg[card_cfg_pkg::CTL_CLOCK_HALT_BIT];
	assign card_clock_level = ctl_reg[card_cfg_pkg::CTL_CLOCK_LEVEL_BIT];

	////////////////////////////////////////////////////////////////////
	// Supply and presence/interrupt pin
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_boost_en <= 1'b0;
			o_pullup_en <= 1'b0;
			o_supply_glitch_monitor_en <= 1'b0;
			o_hw_activate_allowed <= 1'b0;
		end else begin
			o_boost_en <= i_dcdc_on & ~boost_bypass;
			o_pullup_en <= cfg_reg[card_cfg_pkg::CFG_PULLUP_EN_BIT];
			o_supply_glitch_monitor_en <=
				cfg_reg[card_cfg_pkg::CFG_GLITCH_MON_BIT];
			o_hw_activate_allowed <= irq_source_gate;
		end
	end

	logic irq_pull_next;

	always_comb begin
		if (irq_source_gate) begin
			irq_pull_next = i_card_present;
		end else begin
			irq_pull_next = i_insert_irq | i_card_supply_irq | i_other_irq;
		end
	end

	assign o_presence_irq_pin_o = 1'b0;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_presence_irq_pin_oe <= 1'b0;
		end else begin
			o_presence_irq_pin_oe <= irq_pull_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Card reset pin
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_card_reset_pin <= 1'b0;
		end else if (card_reset_source_sel) begin
			// Host reset pin only steers the card during activation
			o_card_reset_pin <= i_hw_activation & pin_sync[4];
		end else begin
			o_card_reset_pin <= ctl_reg[card_cfg_pkg::CTL_CARD_RESET_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Card clock: edges only on prescaler ticks, so halting and
	// resuming never shortens a phase
	card_cfg_pkg::clk_state_type clk_state_reg;
	logic card_clk_reg;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			clk_state_reg <= card_cfg_pkg::CLK_HALTED;
		end else begin
			case (clk_state_reg)
				card_cfg_pkg::CLK_RUN: begin
					if (card_clock_halt) begin
						clk_state_reg <= card_cfg_pkg::CLK_PARKING;
					end
				end
				card_cfg_pkg::CLK_PARKING: begin
					if (!card_clock_halt) begin
						clk_state_reg <= card_cfg_pkg::CLK_RUN;
					end else if (card_clk_reg == card_clock_level ||
							i_card_clk_tick) begin
						clk_state_reg <= card_cfg_pkg::CLK_HALTED;
					end
				end
				card_cfg_pkg::CLK_HALTED: begin
					if (!card_clock_halt) begin
						clk_state_reg <= card_cfg_pkg::CLK_RUN;
					end else if (card_clk_reg != card_clock_level) begin
						clk_state_reg <= card_cfg_pkg::CLK_PARKING;
					end
				end
				default: begin
					clk_state_reg <= card_cfg_pkg::CLK_HALTED;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			card_clk_reg <= 1'b0;
		end else if (i_card_clk_tick &&
				(clk_state_reg == card_cfg_pkg::CLK_RUN ||
				(clk_state_reg == card_cfg_pkg::CLK_PARKING &&
				card_clk_reg != card_clock_level))) begin
			card_clk_reg <= ~card_clk_reg;
		end
	end

	assign o_card_clock_pin = card_clk_reg;

	////////////////////////////////////////////////////////////////////
	// Contact routing
	card_contact_if contact ();

	assign contact.io_isolate = ctl_reg[card_cfg_pkg::CTL_IO_ISOLATE_BIT];
	assign contact.io_level = ctl_reg[card_cfg_pkg::CTL_IO_LEVEL_BIT];
	assign contact.c4_level = ctl_reg[card_cfg_pkg::CTL_C4_LEVEL_BIT];
	assign contact.c8_level = ctl_reg[card_cfg_pkg::CTL_C8_LEVEL_BIT];
	assign contact.host_io_s = pin_sync[0];
	assign contact.host_c4_s = pin_sync[1];
	assign contact.host_c8_s = pin_sync[2];
	assign contact.card_io_s = pin_sync[3];

	card_contact_mux u_mux (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.bus(contact.mux)
	);

	assign o_card_io_pin_o = 1'b0;
	assign o_card_io_pin_oe = contact.card_io_oe;
	assign o_card_c4_pin = contact.card_c4;
	assign o_card_c8_pin = contact.card_c8;
	assign o_host_io_pin_o = 1'b0;
	assign o_host_io_pin_oe = contact.host_io_oe;
endmodule // card_interface_config_regs
`default_nettype wire

// ### shared/card_cfg_pkg.sv
`default_nettype none
package card_cfg_pkg;
	// Register indices on the byte port from the two-wire front end
	localparam logic [1:0] ADDR_POWER_IRQ_CFG = 2'h0;
	localparam logic [1:0] ADDR_CONTACT_CTL = 2'h1;
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;

	// card_power_irq_config field positions
	localparam int CFG_BOOST_BYPASS_BIT = 4;
	localparam int CFG_PULLUP_EN_BIT = 3;
	localparam int CFG_GLITCH_MON_BIT = 2;
	localparam int CFG_IRQ_GATE_BIT = 1;
	localparam int CFG_RST_SRC_BIT = 0;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// card_contact_control field positions
	localparam int CTL_IO_ISOLATE_BIT = 6;
	localparam int CTL_CLOCK_HALT_BIT = 5;
	localparam int CTL_CARD_RESET_BIT = 4;
	localparam int CTL_C8_LEVEL_BIT = 3;
	localparam int CTL_C4_LEVEL_BIT = 2;
	localparam int CTL_CLOCK_LEVEL_BIT = 1;
	localparam int CTL_IO_LEVEL_BIT = 0;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;
	localparam logic [7:0] CTL_RESET = 8'h61;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;
	localparam int PIN_COUNT = 5;

	typedef enum logic [2:0] {
		CLK_RUN = 3'b001,
		CLK_PARKING = 3'b010,
		CLK_HALTED = 3'b100
	} clk_state_type;
endpackage
`default_nettype wire

// ### shared/card_contact_if.sv
`default_nettype none
interface card_contact_if;
	logic io_isolate;
	logic io_level;
	logic c4_level;
	logic c8_level;
	logic host_io_s;
	logic host_c4_s;
	logic host_c8_s;
	logic card_io_s;
	logic card_io_oe;
	logic card_c4;
	logic card_c8;
	logic host_io_oe;

	modport ctl (
		output io_isolate, io_level, c4_level, c8_level,
		output host_io_s, host_c4_s, host_c8_s, card_io_s,
		input card_io_oe, card_c4, card_c8, host_io_oe
	);
	modport mux (
		input io_isolate, io_level, c4_level, c8_level,
		input host_io_s, host_c4_s, host_c8_s, card_io_s,
		output card_io_oe, card_c4, card_c8, host_io_oe
	);
endinterface
`default_nettype wire

// ### logic/card_contact_mux.sv
`default_nettype none
module card_contact_mux (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Contact levels and pins
	card_contact_if.mux bus
);
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus.card_c4 <= 1'b0;
			bus.card_c8 <= 1'b0;
		end else if (bus.io_isolate) begin
			bus.card_c4 <= bus.c4_level;
			bus.card_c8 <= bus.c8_level;
		end else begin
			bus.card_c4 <= bus.host_c4_s;
			bus.card_c8 <= bus.host_c8_s;
		end
	end

	// I/O line is open drain on both sides; the side that pulled
	// first keeps ownership so the two drivers cannot latch low
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus.card_io_oe <= 1'b0;
			bus.host_io_oe <= 1'b0;
		end else if (bus.io_isolate) begin
			bus.card_io_oe <= ~bus.io_level;
			bus.host_io_oe <= 1'b0;
		end else begin
			bus.card_io_oe <= ~bus.host_io_s & ~bus.host_io_oe;
			bus.host_io_oe <= ~bus.card_io_s & ~bus.card_io_oe;
		end
	end
endmodule // card_contact_mux
`default_nettype wire

// ### test/cfg_regs_checker.sv
`default_nettype none
module cfg_regs_checker (
	// Clock and register port
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_reg_wr_en,
	input wire logic [1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	// Controls and pins
	input wire logic i_dcdc_on,
	input wire logic o_boost_en,
	input wire logic i_card_present,
	input wire logic i_insert_irq,
	input wire logic i_card_supply_irq,
	input wire logic i_other_irq,
	input wire logic o_pullup_en,
	input wire logic o_presence_irq_pin_o,
	input wire logic o_presence_irq_pin_oe,
	input wire logic o_hw_activate_allowed,
	input wire logic i_card_clk_tick,
	input wire logic o_card_clock_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////////////
	pin_open_drain_a: assert property (o_presence_irq_pin_o == 1'b0)
		else $error("presence pin driven high");
	irq_gate_set_a: assert property ($stable(o_hw_activate_allowed) &&
		o_hw_activate_allowed |-> o_presence_irq_pin_oe == $past(i_card_present))
		else $error("gated pin not presence");
	irq_gate_clr_a: assert property ($stable(o_hw_activate_allowed) &&
		!o_hw_activate_allowed |-> o_presence_irq_pin_oe ==
		$past(i_insert_irq | i_card_supply_irq | i_other_irq))
		else $error("pin not interrupt sources");
	boost_gate_a: assert property (o_boost_en |-> $past(i_dcdc_on))
		else $error("boost without converter request");
	pullup_write_a: assert property ($changed(o_pullup_en) |->
		$past(i_reg_wr_en, 2) && $past(i_reg_addr, 2) == 2'h0 &&
		$past(i_reg_wdata[3], 2) == o_pullup_en)
		else $error("pull-up change without write");
	cfg_reserved_a: assert property ($past(i_reg_addr) == 2'h0 |->
		o_reg_rdata[7:5] == 3'h0)
		else $error("config reserved bits set");
	ctl_reserved_a: assert property ($past(i_reg_addr) == 2'h1 |->
		o_reg_rdata[7] == 1'b0)
		else $error("contact bit 7 set");
	unmapped_zero_a: assert property ($past(i_reg_addr) >= 2'h2 |->
		o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	clock_on_tick_a: assert property ($changed(o_card_clock_pin) |->
		$past(i_card_clk_tick))
		else $error("card clock moved without tick");
endmodule // cfg_regs_checker
bind card_interface_config_regs cfg_regs_checker u_chk (
	.i_sys_clk, .i_resetn, .i_reg_wr_en, .i_reg_addr, .i_reg_wdata,
	.o_reg_rdata, .i_dcdc_on, .o_boost_en, .i_card_present, .i_insert_irq,
	.i_card_supply_irq, .i_other_irq, .o_pullup_en, .o_presence_irq_pin_o,
	.o_presence_irq_pin_oe, .o_hw_activate_allowed, .i_card_clk_tick,
	.o_card_clock_pin
);
`default_nettype wire

// ### test/host_link.sv
`default_nettype none
module host_link (
	// Clock and read data
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	// Byte port
	output logic o_wr_en,
	output logic [1:0] o_addr,
	output logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr_en = 1'b0;
		o_addr = 2'h0;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr_en = 1'b1;
		o_addr = a;
		o_wdata = (a == 2'h0) ? (d & 8'h1F) : d;
		@(negedge i_clk);
		o_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		repeat (2) @(negedge i_clk);
		d = i_rdata;
	endtask
endmodule // host_link
`default_nettype wire

// ### test/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_resetn, i_dcdc_on, i_card_present, i_insert_irq;
	logic i_card_supply_irq, i_other_irq, i_host_reset_in_pin, i_hw_activation;
	logic i_card_clk_tick, i_host_io_pin, i_host_c4_pin, i_host_c8_pin;
	logic i_card_io_pin, i_reg_wr_en, o_boost_en, o_supply_glitch_monitor_en;
	logic o_pullup_en, o_presence_irq_pin_oe, o_hw_activate_allowed;
	logic o_card_reset_pin, o_card_clock_pin, o_card_io_pin_oe;
	logic o_card_c4_pin, o_card_c8_pin;
	logic o_host_io_pin_oe, o_card_io_pin_o, o_host_io_pin_o;
	logic [1:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, v, c, t;
	logic [31:0] x;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	card_interface_config_regs uut (
		.i_sys_clk, .i_resetn, .i_reg_wr_en, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .i_dcdc_on, .o_boost_en, .o_supply_glitch_monitor_en,
		.i_card_present, .i_insert_irq, .i_card_supply_irq, .i_other_irq,
		.o_pullup_en, .o_presence_irq_pin_o(), .o_presence_irq_pin_oe,
		.i_host_reset_in_pin, .i_hw_activation, .o_hw_activate_allowed,
		.o_card_reset_pin, .i_card_clk_tick, .o_card_clock_pin,
		.i_host_io_pin, .i_host_c4_pin, .i_host_c8_pin, .i_card_io_pin,
		.o_card_io_pin_o, .o_card_io_pin_oe, .o_card_c4_pin, .o_card_c8_pin,
		.o_host_io_pin_o, .o_host_io_pin_oe
	);
	host_link host (.i_clk(i_sys_clk), .i_rdata(o_reg_rdata),
		.o_wr_en(i_reg_wr_en), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Contact level when isolated, else the host pin level
	function automatic logic exp_route(input logic iso, input logic lvl,
			input logic pin);
		return iso ? lvl : pin;
	endfunction
	// Presence pin pull for the given gate setting
	function automatic logic exp_irq(input logic gate);
		return gate ? i_card_present : (i_insert_irq | i_card_supply_irq |
			i_other_irq);
	endfunction
	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	// Prescaler tick on every second cycle
	always @(negedge i_sys_clk) begin
		i_card_clk_tick = cyc[0];
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		i_resetn = 1'b0;
		{i_dcdc_on, i_card_present, i_insert_irq, i_card_supply_irq} = 4'h0;
		{i_other_irq, i_host_reset_in_pin, i_hw_activation} = 3'h0;
		{i_host_io_pin, i_card_io_pin} = 2'h0;
		{i_host_c4_pin, i_host_c8_pin} = 2'h0;
		x = 32'h0000851A;
		repeat (12) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		host.rd(2'h0, v);
		chk("cfg reset", 8'h00, v);
		host.rd(2'h1, v);
		chk("ctl reset", 8'h61, v);
		// No coil fitted: bypass goes in before the converter starts
		host.wr(2'h0, 8'h10);
		@(negedge i_sys_clk);
		i_dcdc_on = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		chkb("boost bypassed", 1'b0, o_boost_en);
		host.wr(2'h0, 8'h00);
		repeat (3) @(negedge i_sys_clk);
		chkb("boost auto", 1'b1, o_boost_en);
		for (int i = 0; i < 40; i++) begin
			x = xs(x);
			// First pass tries all-ones on config (host.wr masks it to 8'h1F) and bit 7 on the contact reserved place
			c = (i == 0) ? 8'hFF : x[7:0];
			t = (i == 0) ? 8'h80 : x[15:8];
			@(negedge i_sys_clk);
			{i_dcdc_on, i_card_present, i_insert_irq, i_card_supply_irq,
				i_other_irq, i_host_reset_in_pin, i_host_c4_pin,
				i_host_c8_pin} = x[23:16];
			{i_host_io_pin, i_card_io_pin} = x[26:25];
			i_hw_activation = 1'b0;
			host.wr(2'h0, c);
			// Activation only starts once the gate is written
			i_hw_activation = x[24] & c[1];
			host.wr(2'h1, t);
			host.wr(2'h2, x[31:24]);
			repeat (6) @(negedge i_sys_clk);
			c = c & 8'h1F;
			t = t & 8'h7F;
			chkb("boost", i_dcdc_on & ~c[4], o_boost_en);
			chkb("pullup", c[3], o_pullup_en);
			chkb("monitor", c[2], o_supply_glitch_monitor_en);
			chkb("hw allowed", c[1], o_hw_activate_allowed);
			chkb("irq pin", exp_irq(c[1]), o_presence_irq_pin_oe);
			chkb("card reset", c[0] ? (i_hw_activation &
				i_host_reset_in_pin) : t[4], o_card_reset_pin);
			chkb("c4", exp_route(t[6], t[2], i_host_c4_pin),
				o_card_c4_pin);
			chkb("c8", exp_route(t[6], t[3], i_host_c8_pin),
				o_card_c8_pin);
			if (t[6]) chkb("io oe", ~t[0], o_card_io_pin_oe);
			if (t[6]) chkb("host io oe", 1'b0, o_host_io_pin_oe);
			chkb("card io out", 1'b0, o_card_io_pin_o);
			chkb("host io out", 1'b0, o_host_io_pin_o);
			if (t[5]) chkb("card clock", t[1], o_card_clock_pin);
			host.rd(2'h0, v);
			chk("cfg", c, v);
			host.rd(2'h1, v);
			chk("ctl", t, v);
			host.rd(2'h2, v);
			chk("unmapped", 8'h00, v);
		end
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
